//--- rtl/amr_pkg.sv
// Package of constants and types for the monitor readout path.
package amr_pkg;

  // ==========================================================================
  // Clock rates and documented times.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int POR_READY_MS    = 500;
  localparam int BUS_TIMEOUT_MS  = 25;
  localparam int CONVERT_MAX_US  = 200;

  // The ready time and the bus timeout round up; the conversion limit rounds down.
  localparam int POR_READY_CYC   =
    (POR_READY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_TIMEOUT_CYC =
    (BUS_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERT_MAX_CYC = (CONVERT_MAX_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Widths and counts.
  localparam int NUM_CHAN    = 6;
  localparam int CODE_W      = 10;
  localparam int RESULT_W    = 12;
  localparam int HIGH_W      = 8;
  localparam int LOW_W       = 4;
  localparam int POR_CNT_W   = 26;
  localparam int TMO_CNT_W   = 22;
  localparam int CONV_CNT_W  = 15;
  localparam int ATTEN_SCALE = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    AMR_WAIT_POR = 2'b00,
    AMR_IDLE     = 2'b01,
    AMR_CONVERT  = 2'b11
  } amr_state_type;

  typedef struct packed {
    logic [2:0] chan;
    logic       atten;
  } amr_req_type;

  typedef struct packed {
    logic [HIGH_W-1:0] high;
    logic [LOW_W-1:0]  low;
  } amr_result_type;

endpackage : amr_pkg

//--- rtl/amr_readout.sv
// Monitor readout: request crossing, converter control, scaling, readout.
//
// Behaviour
// [R1] The converter path has an attenuator set per request to divide by 3 or 1.
// [R2] A measurement request is accepted at any time, even mid-conversion; requests that arrive before portReady rises are dropped.
// [R3] An accepted request steers the input selector to the named input.
// [R4] A finished conversion is captured into the readout registers.
// [R5] With attenuation active the ten-bit code is multiplied by three.
// [R6] The result is a twelve-bit code of two millivolts per step either way.
// [R7] The result reads as an upper eight-bit and a lower four-bit register.
// [R8] Below 50 kHz the host waits the conversion time instead of polling.
// [R9] The completion flag is set once the conversion has finished.
// [R10] The serial clock held low for 25 to 35 ms is flagged as a timeout.
// [R11] The port is operational no later than 500 ms after reset.
// [R12] A conversion completes within 200 us of its request.
// [R13] Accepting a request clears the completion flag until the new result.
module amr_readout #(
  parameter int NUM_CHAN    = amr_pkg::NUM_CHAN,
  parameter int POR_CYC     = amr_pkg::POR_READY_CYC,
  parameter int TIMEOUT_CYC = amr_pkg::BUS_TIMEOUT_CYC,
  parameter int CONVERT_CYC = amr_pkg::CONVERT_MAX_CYC
) (
  // System clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Link side, on the serial port clock.
  input  wire logic                 linkClk,
  input  wire logic                 reqValid,
  input  wire amr_pkg::amr_req_type reqIn,
  output amr_pkg::amr_result_type   readout,
  output logic                      doneFlag,
  // Serial clock pin, watched for the low timeout.
  input  wire logic                 sclIn,
  output logic                      busTimeout,
  output logic                      portReady,
  // Converter macro.
  output logic [2:0]                adcChanSel,
  output logic                      adcAttenDiv3,
  output logic                      adcStart,
  input  wire logic                 adcDone,
  input  wire logic [amr_pkg::CODE_W-1:0] adcCode,
  output logic                      convLate
);

  // ==========================================================================
  // Elaboration checks.
  initial begin
    if (NUM_CHAN < 1 || NUM_CHAN > 8)
      $error("NUM_CHAN must lie in 1 to 8.");
    if (POR_CYC < 1 || POR_CYC >= (1 << amr_pkg::POR_CNT_W))
      $error("POR_CYC does not fit its counter.");
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << amr_pkg::TMO_CNT_W))
      $error("TIMEOUT_CYC does not fit its counter.");
    if (CONVERT_CYC < 1 || CONVERT_CYC >= (1 << amr_pkg::CONV_CNT_W))
      $error("CONVERT_CYC does not fit its counter.");
  end

  localparam logic [amr_pkg::POR_CNT_W-1:0] POR_LAST =
    amr_pkg::POR_CNT_W'(POR_CYC - 1);
  localparam logic [amr_pkg::TMO_CNT_W-1:0] TMO_LAST =
    amr_pkg::TMO_CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [amr_pkg::CONV_CNT_W-1:0] CONV_LAST =
    amr_pkg::CONV_CNT_W'(CONVERT_CYC - 1);
  localparam logic [2:0] CHAN_LIMIT = 3'(NUM_CHAN - 1);

  // Scale a raw code to two millivolts per step.
  function automatic logic [amr_pkg::RESULT_W-1:0] scaleCode(
    input logic [amr_pkg::CODE_W-1:0] code,
    input logic                       atten
  );
    logic [amr_pkg::RESULT_W-1:0] wide;
    wide = {2'b00, code};
    if (atten)
      scaleCode = amr_pkg::RESULT_W'(wide * amr_pkg::ATTEN_SCALE); // [R5]
    else
      scaleCode = wide;
  endfunction

  // ==========================================================================
  // Reset release, one copy per domain.
  logic [1:0] rstSysSync;
  logic [1:0] rstLinkSync;
  logic       sysRst_n;
  logic       linkRst_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rstSysSync <= 2'b00;
    else
      rstSysSync <= {rstSysSync[0], 1'b1};
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n)
      rstLinkSync <= 2'b00;
    else
      rstLinkSync <= {rstLinkSync[0], 1'b1};
  end

  assign sysRst_n  = rstSysSync[1];
  assign linkRst_n = rstLinkSync[1];

  // ==========================================================================
  // Link domain state.
  typedef struct packed {
    logic                    reqTog;
    amr_pkg::amr_req_type    hold;
    logic [2:0]              doneSync;
    logic                    done;
    amr_pkg::amr_result_type readout;
  } amr_link_type;

  // ==========================================================================
  // System domain state.
  typedef struct packed {
    amr_pkg::amr_state_type             state;
    logic [2:0]                         togSync;
    amr_pkg::amr_req_type               req;
    logic                               start;
    logic [amr_pkg::RESULT_W-1:0]       result;
    logic                               done;
    logic                               late;
    logic [1:0]                         sclSync;
    logic [amr_pkg::TMO_CNT_W-1:0]      sclLowCnt;
    logic                               timeout;
    logic [amr_pkg::POR_CNT_W-1:0]      porCnt;
    logic [amr_pkg::CONV_CNT_W-1:0]     convCnt;
    logic                               ready;
  } amr_sys_type;

  amr_link_type link_r;
  amr_link_type link_nxt;
  amr_sys_type  sys_r;
  amr_sys_type  sys_nxt;

  // Link side: a request is held steady and announced by a toggle, so the
  // system side reads the held fields only after the toggle has settled.
  always_comb begin
    link_nxt = link_r;
    link_nxt.doneSync = {link_r.doneSync[1:0], sys_r.done};
    if (reqValid) begin
      link_nxt.hold   = reqIn; // [R2]
      link_nxt.reqTog = ~link_r.reqTog;
      link_nxt.done   = 1'b0; // [R13]
    end
    // The result words are stable while the system done level is high.
    if (link_r.doneSync[1] && !link_r.doneSync[2]) begin
      link_nxt.readout.high = sys_r.result[11:4]; // [R7]
      link_nxt.readout.low  = sys_r.result[3:0]; // [R7]
      link_nxt.done         = 1'b1; // [R9]
    end
  end

  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n)
      link_r <= '0;
    else
      link_r <= link_nxt;
  end

  // System side: request acceptance, converter sequencing, watchdogs.
  always_comb begin
    logic newReq;
    logic chanOk;
    newReq = 1'b0;
    chanOk = 1'b0;
    sys_nxt = sys_r;
    sys_nxt.start   = 1'b0;
    sys_nxt.togSync = {sys_r.togSync[1:0], link_r.reqTog};
    sys_nxt.sclSync = {sys_r.sclSync[0], sclIn};

    // Clock-low watch; it rearms as soon as the clock is released.
    if (sys_r.sclSync[1]) begin
      sys_nxt.sclLowCnt = '0;
      sys_nxt.timeout   = 1'b0;
    end else if (sys_r.sclLowCnt == TMO_LAST) begin
      sys_nxt.timeout = 1'b1; // [R10]
    end else begin
      sys_nxt.sclLowCnt = sys_r.sclLowCnt + 1'b1;
    end

    newReq = sys_r.togSync[2] != sys_r.togSync[1];
    chanOk = link_r.hold.chan <= CHAN_LIMIT;

    unique case (sys_r.state)
      amr_pkg::AMR_WAIT_POR: begin
        // Requests seen while settling are dropped; the host must wait.
        if (sys_r.porCnt == POR_LAST) begin
          sys_nxt.state = amr_pkg::AMR_IDLE; // [R11]
          sys_nxt.ready = 1'b1;
        end else begin
          sys_nxt.porCnt = sys_r.porCnt + 1'b1;
        end
      end
      amr_pkg::AMR_IDLE, amr_pkg::AMR_CONVERT: begin
        if (sys_r.state == amr_pkg::AMR_CONVERT) begin
          if (adcDone) begin
            sys_nxt.result = scaleCode(adcCode, sys_r.req.atten); // [R4] [R6]
            sys_nxt.done   = 1'b1; // [R9]
            sys_nxt.state  = amr_pkg::AMR_IDLE;
          end else if (sys_r.convCnt == CONV_LAST) begin
            sys_nxt.late = 1'b1; // [R12]
          end else begin
            sys_nxt.convCnt = sys_r.convCnt + 1'b1;
          end
        end
        // A new request restarts the converter even mid-conversion.
        if (newReq && chanOk) begin
          sys_nxt.req     = link_r.hold; // [R2] [R3] [R1]
          sys_nxt.start   = 1'b1;
          sys_nxt.done    = 1'b0; // [R13]
          sys_nxt.late    = 1'b0;
          sys_nxt.convCnt = '0;
          sys_nxt.state   = amr_pkg::AMR_CONVERT;
        end
      end
      default: begin
        sys_nxt.state = amr_pkg::AMR_WAIT_POR;
      end
    endcase
  end

  always_ff @(posedge clock or negedge sysRst_n) begin
    if (!sysRst_n) begin
      sys_r        <= '0;
      sys_r.state  <= amr_pkg::AMR_WAIT_POR;
      sys_r.result <= amr_pkg::RESULT_RST;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop.
  assign readout      = link_r.readout;
  assign doneFlag     = link_r.done;
  assign busTimeout   = sys_r.timeout;
  assign portReady    = sys_r.ready;
  assign adcChanSel   = sys_r.req.chan; // [R3]
  assign adcAttenDiv3 = sys_r.req.atten; // [R1]
  assign adcStart     = sys_r.start;
  assign convLate     = sys_r.late;

endmodule // amr_readout

//--- verification/amr_adc_model.sv
// Converter model that answers a start after a set latency.
module amr_adc_model (
  input wire logic       clock, rst_n, adcStart,
  input wire logic [7:0] modelLat,
  input wire logic [9:0] modelCode,
  output logic           adcDone,
  output logic [9:0]     adcCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // ==========
  // A restart drops the one in flight; latency 0 never answers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      adcDone <= 1'b0;
      adcCode <= '0;
    end else begin
      adcDone <= (cnt == 8'h01);
      adcCode <= (cnt == 8'h01) ? modelCode : ~adcCode;
      cnt <= adcStart ? modelLat : (cnt != 0) ? cnt - 8'h01 : cnt;
    end
  end
endmodule // amr_adc_model

//--- verification/amr_readout_sva.sv
// Checker of the monitor readout path.
module amr_readout_sva #(
  parameter int POR_CYC     = 50,
  parameter int TIMEOUT_CYC = 40,
  parameter int CONVERT_CYC = 30,
  parameter int NUM_CHAN    = 6
) (
  input wire logic clock, rst_n, linkClk, reqValid, doneFlag, sclIn,
  input wire logic busTimeout, portReady, adcAttenDiv3, adcStart,
  input wire logic adcDone, convLate,
  input wire logic [2:0] adcChanSel,
  input wire amr_pkg::amr_result_type readout
);
  timeunit 1ns;
  timeprecision 1ps;
  int lowCnt, upCnt, convCnt;
  // ==========
  // Counters give the timed rules an exact yardstick.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 0;
      upCnt <= 0;
      convCnt <= 0;
    end else begin
      lowCnt <= sclIn ? 0 : lowCnt + 1;
      upCnt <= upCnt + 1;
      convCnt <= adcStart ? 1 : adcDone ? 0 : convCnt + (convCnt != 0);
    end
  end
  chk_start_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    adcStart |=> !adcStart) else $error("long start");
  chk_sel_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    adcStart |-> adcChanSel < NUM_CHAN) else $error("bad channel");
  chk_sel_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed({adcChanSel, adcAttenDiv3}) |-> adcStart)
    else $error("sel moved");
  chk_start_ready: assert property (
    @(posedge clock) disable iff (!rst_n)
    adcStart |-> portReady) else $error("early start");
  chk_ready_time: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(portReady) |-> upCnt inside {[POR_CYC:POR_CYC+5]})
    else $error("ready time");
  chk_tmo_rise: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(busTimeout) |-> lowCnt inside {[TIMEOUT_CYC:TIMEOUT_CYC+4]})
    else $error("timeout early or late");
  chk_tmo_fall: assert property (
    @(posedge clock) disable iff (!rst_n)
    sclIn [*4] |-> !busTimeout) else $error("timeout stuck");
  chk_late_time: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(convLate) |-> convCnt inside {[CONVERT_CYC-2:CONVERT_CYC+2]})
    else $error("late flag time");
  chk_done_clear: assert property (
    @(posedge linkClk) disable iff (!rst_n)
    reqValid |=> !doneFlag) else $error("done not cleared");
  chk_result_hold: assert property (
    @(posedge linkClk) disable iff (!rst_n)
    !doneFlag ##1 !doneFlag |-> $stable(readout)) else $error("result moved");
  cov_done: cover property (@(posedge linkClk) $rose(doneFlag));
  cov_tmo: cover property (@(posedge clock) $rose(busTimeout));
  cov_late: cover property (@(posedge clock) $rose(convLate));
endmodule // amr_readout_sva

bind amr_readout amr_readout_sva #(.POR_CYC(POR_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC), .CONVERT_CYC(CONVERT_CYC),
  .NUM_CHAN(NUM_CHAN)) chk_u (.*);

//--- verification/amr_readout_tb_top.sv
// Self-checking bench for the monitor readout path.
module amr_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, linkClk = 0, linkOn = 1, reqValid = 0;
  logic sclIn = 1, doneFlag, busTimeout, portReady, adcAttenDiv3;
  logic adcStart, adcDone, convLate, prevDone = 0;
  logic [2:0] adcChanSel;
  logic [7:0] modelLat = 8'h05;
  logic [9:0] adcCode, modelCode = '0;
  amr_pkg::amr_req_type reqIn = '0;
  amr_pkg::amr_result_type readout;
  int n_errors = 0, num_checks = 0, cycles = 0, nStarts = 0, n0;
  logic [11:0] expQ[$];
  amr_readout #(.POR_CYC(50), .TIMEOUT_CYC(40), .CONVERT_CYC(30)) dut_u (.*);
  amr_adc_model model_u (.*);
  // ==========
  // The link clock runs through reset, or the link side never leaves it.
  // It stops low once measurement traffic is over.
  always #5 clock = ~clock;
  always #32 if (linkOn || linkClk) linkClk = ~linkClk;
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Notes the expected result only when a completion should follow.
  task automatic req(logic [2:0] ch, logic at, logic [7:0] lat, bit keep);
    @(posedge linkClk) #1;
    modelCode = 10'($urandom_range(1023));
    modelLat = lat;
    reqIn = '{ch, at};
    reqValid = 1;
    if (keep) expQ.push_back(at ? modelCode * 3 : {2'h0, modelCode});
    @(posedge linkClk) #1 reqValid = 0;
    check(doneFlag, 0);
  endtask
  task automatic waitDone();
    repeat (300) @(posedge clock) if (expQ.size() == 0) break;
    check(expQ.size(), 0);
  endtask
  // Each rising completion flag consumes the oldest note.
  always @(posedge linkClk) begin
    #2;
    if (doneFlag && !prevDone) begin
      if (expQ.size() == 0) check(1, 0);
      else check(readout, expQ.pop_front());
    end
    prevDone = doneFlag;
  end
  always @(posedge clock) if (adcStart) begin
    nStarts++;
    check({adcChanSel, adcAttenDiv3}, reqIn);
  end
  always @(posedge clock) if (++cycles > 20000) begin
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h1641325f));
    repeat (10) @(posedge clock);
    #1 rst_n = 1;
    // Ready rises about POR_CYC + 2 cycles after release.
    repeat (40) @(posedge clock);
    check(portReady, 0);
    repeat (30) @(posedge clock);
    check(portReady, 1);
    for (int i = 0; i < 12; i++) begin
      req(3'(i / 2), 1'(i % 2), 8'(1 + 2 * i), 1);
      waitDone();
    end
    $display("test channels done");
    // A slow host waits a fixed conversion time instead of polling.
    req(3'h5, 1, 8'h14, 1);
    repeat (80) @(posedge clock);
    check(expQ.size(), 0);
    $display("test fixed wait done");
    req(3'h1, 0, 8'h14, 0);
    req(3'h2, 1, 8'h05, 1);
    waitDone();
    $display("test restart done");
    n0 = nStarts;
    req(3'h6, 0, 8'h05, 0);
    req(3'h7, 1, 8'h05, 0);
    repeat (100) @(posedge clock);
    check(nStarts - n0, 0);
    check(doneFlag, 0);
    $display("test bad channel done");
    req(3'h3, 0, 8'h00, 0);
    repeat (40) @(posedge clock);
    check(convLate, 1);
    req(3'h4, 1, 8'h03, 1);
    waitDone();
    check(convLate, 0);
    $display("test late done");
    linkOn = 0;
    #1 sclIn = 0;
    repeat (20) @(posedge clock);
    check(busTimeout, 0);
    repeat (30) @(posedge clock);
    check(busTimeout, 1);
    #1 sclIn = 1;
    repeat (6) @(posedge clock);
    check(busTimeout, 0);
    $display("test timeout done");
    give_verdict();
  end
endmodule // amr_readout_tb_top
